// ---- src/icfr_top.sv ----
/*
 * Calibration, Bartlett filter, averaging decimator, register bank and
 * mode-3 serial peripheral of a six-axis inertial sensor.
 * Assumes raw axis words are stable whenever the sample strobe is taken,
 * and that serial clock, select, data and sync pins are asynchronous.
 */
`timescale 1ns/1ps

// Summary of operation
// - Gyro: scale matrix times raw plus bias.
// - Add linear-g matrix times corrected acceleration.
// - Accel: scale matrix times raw, plus bias.
// - Add percussion matrix times squared corrected rates.
// - Coefficients fixed inside, never host visible.
// - Control bit 7 enables linear-g term.
// - Control bit 6 enables percussion term.
// - Two cascaded averagers form Bartlett filter.
// - Average N samples, update every N.
// - Sixteen-bit registers, each byte separately addressed.
// - Serial mode 3, peripheral only.
// - Sixteen-bit words, most significant bit first.
// - Ready pulse on each output update.
// - Control bit 0 sets pulse polarity, default 1.
// - Internal clock gives 2000 samples per second.
// - Read: request word, reply next word.
// - Control bits 4 to 2 pick clock source.
module icfr_top #(
   parameter int SAMPLE_CYC = icfr_pkg::SAMPLE_CYC,
   parameter int FIFO_DEPTH = 16,
   parameter int FILT_LOG   = 2,
   parameter int DECIM_W    = 11
) (
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        srst_i,
   // Raw sensor words
   input  wire logic [15:0] gyro_raw_i [3],
   input  wire logic [15:0] accl_raw_i [3],
   output logic             raw_take_o,
   // External sync pin
   input  wire logic        sync_i,
   // Serial peripheral pins
   input  wire logic        spi_sclk_i,
   input  wire logic        spi_cs_n_i,
   input  wire logic        spi_mosi_i,
   output logic             spi_miso_o,
   output logic             spi_miso_oe_o,
   // Data ready pin
   output logic             sample_ready_o
);
   localparam int TAPS = 1 << FILT_LOG;

   initial
   begin
      if (FILT_LOG < 0 || FILT_LOG > 3 || DECIM_W < 1 || DECIM_W > 15)
         $error("icfr_top: FILT_LOG or DECIM_W out of range");
      if (SAMPLE_CYC < 2)
         $error("icfr_top: SAMPLE_CYC too small");
   end

   function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
      if (v > 48'sh007fff)
         sat16 = 16'sh7fff;
      else if (v < -48'sh008000)
         sat16 = -16'sh8000;
      else
         sat16 = v[15:0];
   endfunction : sat16

   // ------------------------------------------------------------------
   // Input synchronisers: sclk, cs_n, mosi, sync
   // ------------------------------------------------------------------
   logic [3:0] s1_q;
   logic [3:0] s2_q;
   logic [3:0] s3_q;

   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         s1_q <= 4'hb;
         s2_q <= 4'hb;
         s3_q <= 4'hb;
      end
      else
      begin
         s1_q <= {sync_i, spi_mosi_i, spi_cs_n_i, spi_sclk_i};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   logic sck_rise;
   logic sck_fall;
   logic cs_act;
   logic sync_rise;
   assign sck_rise  = s2_q[0] & ~s3_q[0];
   assign sck_fall  = ~s2_q[0] & s3_q[0];
   assign cs_act    = ~s2_q[1];
   assign sync_rise = s2_q[3] & ~s3_q[3];

   // ------------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------------
   logic [15:0] misc_q;
   logic [15:0] filt_q;
   logic [15:0] decim_q;
   logic        soft_rst_q;
   logic        wr_en;
   logic [6:0]  wr_addr;
   logic [7:0]  wr_byte;
   logic        rst_all;
   assign rst_all = srst_i | soft_rst_q;

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_all)
      begin
         misc_q  <= icfr_pkg::MISC_RST;
         filt_q  <= icfr_pkg::FILT_RST;
         decim_q <= icfr_pkg::DECIM_RST;
      end
      else if (wr_en)
      begin
         unique case ({wr_addr[6:1], 1'b0})
            icfr_pkg::A_MISC:
               if (wr_addr[0]) misc_q[15:8] <= wr_byte;
               else misc_q[7:0] <= wr_byte;
            icfr_pkg::A_FILT:
               if (wr_addr[0]) filt_q[15:8] <= wr_byte;
               else filt_q[7:0] <= wr_byte;
            icfr_pkg::A_DECIM:
               if (wr_addr[0]) decim_q[15:8] <= wr_byte;
               else decim_q[7:0] <= wr_byte;
            default: ;
         endcase
      end
   end

   // Command reset clears the pipeline and every control register.
   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
         soft_rst_q <= 1'b0;
      else
         soft_rst_q <= wr_en & (wr_addr == icfr_pkg::A_GCMD)
                       & wr_byte[icfr_pkg::GCMD_RST];
   end

   // ------------------------------------------------------------------
   // Sample timing and clock source selection
   // ------------------------------------------------------------------
   logic [$clog2(SAMPLE_CYC)-1:0] tmr_q;
   logic                          pend_q;
   logic                          tick;
   logic                          ext_sel;
   logic                          f_ready;
   assign ext_sel    = misc_q[icfr_pkg::MISC_CS_LO +: 3] != icfr_pkg::CS_INT;
   assign tick       = ext_sel ? sync_rise : (tmr_q == '0);
   assign raw_take_o = pend_q & f_ready;

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_all)
         tmr_q <= '0;
      else if (tmr_q == SAMPLE_CYC - 1)
         tmr_q <= '0;
      else
         tmr_q <= tmr_q + 1'b1;
   end

   // A full FIFO holds the sample request until room appears.
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_all)
         pend_q <= 1'b0;
      else if (tick)
         pend_q <= 1'b1;
      else if (raw_take_o)
         pend_q <= 1'b0;
   end

   // ------------------------------------------------------------------
   // Calibration
   // ------------------------------------------------------------------
   logic signed [15:0] gc_q [3];
   logic signed [15:0] ac_q [3];
   logic signed [15:0] gc_d [3];
   logic signed [15:0] ac_d [3];
   logic               cal_v_q;

   // Each correction uses the other sensor's previous corrected sample,
   // which breaks the loop between the two formulas at one sample lag.
   always_comb
   begin
      logic signed [47:0] sg;
      logic signed [47:0] sa;
      logic signed [47:0] sq;
      sg = '0;
      sa = '0;
      sq = '0;
      for (int i = 0; i < 3; i++)
      begin
         sg = '0;
         sa = '0;
         for (int j = 0; j < 3; j++)
         begin
            sg = sg + icfr_pkg::G_M[i][j]
                 * ($signed(gyro_raw_i[j]) + icfr_pkg::G_B[j]);
            sa = sa + icfr_pkg::A_M[i][j] * $signed(accl_raw_i[j]);
         end
         sg = sg >>> icfr_pkg::QSH;
         sa = (sa >>> icfr_pkg::QSH) + icfr_pkg::A_B[i];
         for (int j = 0; j < 3; j++)
         begin
            if (misc_q[icfr_pkg::MISC_LG])
               sg = sg + ((icfr_pkg::G_L[i][j] * ac_q[j])
                          >>> icfr_pkg::QSH);
            sq = (gc_q[j] * gc_q[j]) >>> icfr_pkg::SQSH;
            if (misc_q[icfr_pkg::MISC_POP])
               sa = sa + ((icfr_pkg::A_P[i][j] * sq)
                          >>> icfr_pkg::QSH);
         end
         gc_d[i] = sat16(sg);
         ac_d[i] = sat16(sa);
      end
   end

   // Coefficients are package constants with no path to the serial bank.
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_all)
      begin
         gc_q    <= '{default: '0};
         ac_q    <= '{default: '0};
         cal_v_q <= 1'b0;
      end
      else
      begin
         cal_v_q <= raw_take_o;
         if (raw_take_o)
         begin
            gc_q <= gc_d;
            ac_q <= ac_d;
         end
      end
   end

   // ------------------------------------------------------------------
   // Bartlett filter and averaging decimator, one lane per axis
   // ------------------------------------------------------------------
   logic [1:0]         flen;
   logic [DECIM_W-1:0] dcnt_q;
   logic               dlast;
   logic               flt_v_q;
   logic [95:0]        dec_word;
   assign flen  = (filt_q[1:0] > FILT_LOG) ? 2'(FILT_LOG) : filt_q[1:0];
   assign dlast = (dcnt_q >= decim_q[DECIM_W-1:0]);

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_all)
      begin
         flt_v_q <= 1'b0;
         dcnt_q  <= '0;
      end
      else
      begin
         flt_v_q <= cal_v_q;
         if (flt_v_q)
            dcnt_q <= dlast ? '0 : dcnt_q + 1'b1;
      end
   end

   genvar ax;
   generate
      for (ax = 0; ax < 6; ax++)
      begin : g_lane
         logic signed [15:0] h1_q [TAPS];
         logic signed [15:0] h2_q [TAPS];
         logic signed [15:0] f1;
         logic signed [15:0] f2_q;
         logic signed [31:0] acc_q;
         logic signed [31:0] tot;
         logic signed [31:0] avg;
         logic signed [15:0] x;
         assign x = (ax < 3) ? gc_q[ax % 3] : ac_q[ax % 3];

         // Two equal-length boxcar stages give a triangular window.
         always_comb
         begin
            logic signed [19:0] s1;
            s1 = 20'(x);
            for (int t = 1; t < TAPS; t++)
               if (t < (1 << flen))
                  s1 = s1 + 20'(h1_q[t-1]);
            f1 = 16'(s1 >>> flen);
         end

         always_ff @(posedge clk_sys_i)
         begin
            logic signed [19:0] s2;
            if (rst_all)
            begin
               h1_q <= '{default: '0};
               h2_q <= '{default: '0};
               f2_q <= '0;
            end
            else if (cal_v_q)
            begin
               s2 = 20'(f1);
               for (int t = 1; t < TAPS; t++)
                  if (t < (1 << flen))
                     s2 = s2 + 20'(h2_q[t-1]);
               f2_q <= 16'(s2 >>> flen);
               h1_q[0] <= x;
               h2_q[0] <= f1;
               for (int t = 1; t < TAPS; t++)
               begin
                  h1_q[t] <= h1_q[t-1];
                  h2_q[t] <= h2_q[t-1];
               end
            end
         end

         always_ff @(posedge clk_sys_i)
         begin
            if (rst_all)
               acc_q <= '0;
            else if (flt_v_q)
               acc_q <= dlast ? '0 : tot;
         end

         assign tot = acc_q + 32'(f2_q);
         // Division by the low DECIM_W bits of the decimation register plus one lets any factor up to 2 to the power DECIM_W be exact.
         assign avg = tot / $signed({16'h0000, 16'(decim_q[DECIM_W-1:0])}
                                    + 32'sh1);
         assign dec_word[ax*16 +: 16] = sat16(48'(avg));
      end
   endgenerate

   // ------------------------------------------------------------------
   // Output FIFO and output registers
   // ------------------------------------------------------------------
   icfr_fifo_if #(.W(96)) fq ();
   icfr_fifo #(.W(96), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys_i (clk_sys_i),
      .srst_i    (rst_all),
      .f         (fq)
   );

   logic [15:0] out_q [6];
   logic        upd;
   assign fq.in_valid  = flt_v_q & dlast;
   assign fq.in_data   = dec_word;
   assign f_ready      = fq.in_ready;
   // Output registers only change between serial words.
   assign fq.out_ready = ~cs_act;
   assign upd          = fq.out_valid & fq.out_ready;

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_all)
         out_q <= '{default: '0};
      else if (upd)
         for (int i = 0; i < 6; i++)
            out_q[i] <= fq.out_data[i*16 +: 16];
   end

   // ------------------------------------------------------------------
   // Data ready pulse
   // ------------------------------------------------------------------
   logic [$clog2(icfr_pkg::RDY_WIDTH_CYC+1)-1:0] rdy_cnt_q;
   logic                                         rdy_act;
   assign rdy_act = (rdy_cnt_q != '0);

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_all)
         rdy_cnt_q <= '0;
      else if (upd)
         rdy_cnt_q <= ($bits(rdy_cnt_q))'(icfr_pkg::RDY_WIDTH_CYC);
      else if (rdy_act)
         rdy_cnt_q <= rdy_cnt_q - 1'b1;
   end

   // Polarity 1 idles high, so the trailing edge of the pulse is rising.
   // Reset drives the idle level of the default polarity, which keeps a
   // false edge off the pin when reset ends.
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_all)
         sample_ready_o <= icfr_pkg::MISC_RST[icfr_pkg::MISC_POL];
      else
         sample_ready_o <= rdy_act ^ misc_q[icfr_pkg::MISC_POL];
   end

   // ------------------------------------------------------------------
   // Serial peripheral, mode 3
   // ------------------------------------------------------------------
   logic [15:0] rx_q;
   logic [15:0] tx_q;
   logic [3:0]  bit_q;
   logic [15:0] word;
   logic        wdone;
   logic [15:0] rd_val;
   logic [6:0]  rd_addr;
   assign word    = {rx_q[14:0], s2_q[2]};
   assign wdone   = cs_act & sck_rise & (bit_q == 4'hf);
   assign rd_addr = {word[14:9], 1'b0};
   assign wr_en   = wdone & word[15];
   assign wr_addr = word[14:8];
   assign wr_byte = word[7:0];

   always_comb
   begin
      rd_val = 16'h0000;
      if (rd_addr == icfr_pkg::A_MISC)
         rd_val = misc_q;
      else if (rd_addr == icfr_pkg::A_FILT)
         rd_val = filt_q;
      else if (rd_addr == icfr_pkg::A_DECIM)
         rd_val = decim_q;
      else if (rd_addr == icfr_pkg::A_PROD)
         rd_val = icfr_pkg::PRODUCT_IDENTIFIER_REGISTER;
      for (int i = 0; i < 6; i++)
         if (rd_addr == icfr_pkg::A_OUT_BASE + 7'(2 * i))
            rd_val = out_q[i];
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i | ~cs_act)
      begin
         rx_q  <= '0;
         bit_q <= '0;
      end
      else if (sck_rise)
      begin
         rx_q  <= word;
         bit_q <= bit_q + 1'b1;
      end
   end

   // Reply loads at the end of a read word and leaves on the next one.
   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
         tx_q <= '0;
      else if (wdone)
         tx_q <= word[15] ? 16'h0000 : rd_val;
      else if (cs_act & sck_fall & (bit_q != 4'h0))
         tx_q <= {tx_q[14:0], 1'b0};
   end

   assign spi_miso_o    = tx_q[15];
   assign spi_miso_oe_o = cs_act;

endmodule : icfr_top

// ---- src/icfr_pkg.sv ----
/*
 * Constants, coefficient tables and types for the inertial calibration,
 * filter and serial readout block.
 * Assumes a 20 MHz system clock and a 16-bit sample from each sensor axis.
 */
package icfr_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_HZ          = 20000000;
   localparam int SAMPLE_HZ       = 2000;
   localparam int SAMPLE_CYC      = CLK_HZ / SAMPLE_HZ;
   localparam int RDY_WIDTH_NS    = 1000;
   localparam int CLK_NS          = 50;
   localparam int RDY_WIDTH_CYC   = (RDY_WIDTH_NS + CLK_NS - 1) / CLK_NS;

   // ------------------------------------------------------------------
   // Register byte addresses (even = lower byte, odd = upper byte)
   // ------------------------------------------------------------------
   localparam logic [6:0] A_OUT_BASE  = 7'h04;
   localparam logic [6:0] A_FILT      = 7'h5c;
   localparam logic [6:0] A_MISC      = 7'h60;
   localparam logic [6:0] A_DECIM     = 7'h64;
   localparam logic [6:0] A_GCMD      = 7'h68;
   localparam logic [6:0] A_PROD      = 7'h72;
   // Identifier value is arbitrary.
   localparam logic [15:0] PRODUCT_IDENTIFIER_REGISTER    = 16'h1234;

   // ------------------------------------------------------------------
   // Fields and reset values
   // ------------------------------------------------------------------
   localparam int MISC_POL      = 0;
   localparam int MISC_CS_LO    = 2;
   localparam int MISC_POP      = 6;
   localparam int MISC_LG       = 7;
   localparam int GCMD_RST      = 7;
   localparam logic [15:0] MISC_RST  = 16'h00c1;
   localparam logic [15:0] FILT_RST  = 16'h0000;
   localparam logic [15:0] DECIM_RST = 16'h0000;
   localparam logic [2:0]  CS_INT    = 3'h0;

   // ------------------------------------------------------------------
   // Fixed-point coefficients, Q2.14 (16384 = 1.0)
   // ------------------------------------------------------------------
   localparam int QSH  = 14;
   localparam int SQSH = 16;
   typedef logic signed [15:0] icfr_mat_t [3][3];
   typedef logic signed [15:0] icfr_vec_t [3];
   localparam icfr_mat_t G_M = '{'{16'sh4000, 16'sh0000, 16'sh0000},
                                 '{16'sh0000, 16'sh4000, 16'sh0000},
                                 '{16'sh0000, 16'sh0000, 16'sh4000}};
   localparam icfr_vec_t G_B = '{16'sh0000, 16'sh0000, 16'sh0000};
   localparam icfr_mat_t G_L = '{'{16'sh0000, 16'sh0010, 16'sh0000},
                                 '{16'sh0000, 16'sh0000, 16'sh0010},
                                 '{16'sh0010, 16'sh0000, 16'sh0000}};
   localparam icfr_mat_t A_M = G_M;
   localparam icfr_vec_t A_B = G_B;
   localparam icfr_mat_t A_P = '{'{16'sh0000, 16'sh0020, 16'sh0020},
                                 '{16'sh0020, 16'sh0000, 16'sh0020},
                                 '{16'sh0020, 16'sh0020, 16'sh0000}};

   typedef enum logic [1:0] {
      ICFR_CAL  = 2'b00,
      ICFR_FILT = 2'b01,
      ICFR_DECI = 2'b11
   } icfr_stage_t;

endpackage : icfr_pkg

// ---- src/icfr_fifo_if.sv ----
/*
 * Valid/ready carrier between the sample pipeline and its output FIFO.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface icfr_fifo_if #(
   parameter int W = 96
);
   logic         in_valid;
   logic         in_ready;
   logic [W-1:0] in_data;
   logic         out_valid;
   logic         out_ready;
   logic [W-1:0] out_data;

   modport user (output in_valid, input in_ready, output in_data,
                 input out_valid, output out_ready, input out_data);
   modport fifo (input in_valid, output in_ready, input in_data,
                 output out_valid, input out_ready, output out_data);
endinterface : icfr_fifo_if

// ---- src/icfr_fifo.sv ----
/*
 * First-word-fall-through FIFO whose head word sits in a register.
 * Assumes the carrier interface and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module icfr_fifo #(
   parameter int W     = 96,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic clk_sys_i,
   input  wire logic srst_i,
   // Carrier
   icfr_fifo_if.fifo f
);
   localparam int AW = $clog2(DEPTH);

   initial
   begin
      if (DEPTH < 2 || (1 << AW) != DEPTH)
         $error("icfr_fifo: DEPTH must be a power of two of at least 2");
   end

   logic [W-1:0] mem_q [DEPTH];
   logic [AW:0]  wp_q;
   logic [AW:0]  rp_q;
   logic         ov_q;
   logic [W-1:0] od_q;
   logic         empty;
   logic         full;
   logic         push;
   logic         load;

   // Memory count excludes the head register, so the FIFO holds DEPTH+1.
   assign empty      = (wp_q == rp_q);
   assign full       = (wp_q == {~rp_q[AW], rp_q[AW-1:0]});
   assign f.in_ready = ~full;
   assign push       = f.in_valid & ~full;
   assign load       = ~empty & (~ov_q | f.out_ready);
   assign f.out_valid = ov_q;
   assign f.out_data  = od_q;

   always_ff @(posedge clk_sys_i)
   begin
      if (push)
         mem_q[wp_q[AW-1:0]] <= f.in_data;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         wp_q <= '0;
         rp_q <= '0;
      end
      else
      begin
         if (push)
            wp_q <= wp_q + 1'b1;
         if (load)
            rp_q <= rp_q + 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         ov_q <= 1'b0;
         od_q <= '0;
      end
      else if (load)
      begin
         ov_q <= 1'b1;
         od_q <= mem_q[rp_q[AW-1:0]];
      end
      else if (f.out_ready)
         ov_q <= 1'b0;
   end

endmodule : icfr_fifo

// ---- verification/icfr_props.sv ----
/* Checker for the readout top: pulse, select and reset relations.
   Sees only the ports of the top and is bound to it below. */
`timescale 1ns/1ps
module icfr_props (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // Watched pins
   input wire logic raw_take_o,
   input wire logic spi_cs_n_i,
   input wire logic spi_miso_oe_o,
   input wire logic sample_ready_o
);
   // ------
   // Properties
   // ------
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   sequence s_hold;
      $stable(sample_ready_o) [*8];
   endsequence
   sequence s_boot;
      $fell(srst_i) ##0 spi_cs_n_i [*4];
   endsequence
   // Polarity writes and command resets move the pin near select activity,
   // so only changes after a quiet select count as pulse edges.
   sequence s_edge;
      spi_cs_n_i [*8] ##0 $changed(sample_ready_o);
   endsequence
   a_take_single: assert property (raw_take_o |=> !raw_take_o)
      else $error("take pulse too long");
   a_boot_take: assert property ($fell(srst_i) |-> ##[0:4] raw_take_o)
      else $error("no sample after reset");
   a_boot_ready: assert property (s_boot |-> ##[0:10] $changed(sample_ready_o))
      else $error("no ready pulse after reset");
   a_ready_width: assert property (s_edge |=> s_hold)
      else $error("ready pulse too short");
   a_oe_follow: assert property ($fell(spi_cs_n_i) |-> ##[1:4] spi_miso_oe_o)
      else $error("output not enabled");
   a_oe_release: assert property ($rose(spi_cs_n_i) |-> ##[1:4] !spi_miso_oe_o)
      else $error("output not released");
   a_oe_quiet: assert property (spi_cs_n_i [*4] |-> !spi_miso_oe_o)
      else $error("output driven while idle");
   // Reset itself must be watched, so this one is never disabled.
   a_reset_quiet: assert property (disable iff (1'b0) srst_i |=>
      !(spi_miso_oe_o || raw_take_o) && sample_ready_o)
      else $error("pins active in reset");
endmodule : icfr_props

bind icfr_top icfr_props i_props (.clk_sys_i, .srst_i, .raw_take_o,
   .spi_cs_n_i, .spi_miso_oe_o, .sample_ready_o);

// ---- verification/icfr_host_model.sv ----
/* Host controller model for the mode-3 serial link, 400 ns clock.
   Assumes the bench calls xfer for one word at a time. */
`timescale 1ns/1ps
module icfr_host_model (
   // Serial pins
   output logic      spi_sclk_o,
   output logic      spi_cs_n_o,
   output logic      spi_mosi_o,
   input  wire logic spi_miso_i
);
   // ------
   // Word transfer
   // ------
   initial
   begin
      spi_sclk_o = 1'b1;
      spi_cs_n_o = 1'b1;
      spi_mosi_o = 1'b0;
   end
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      spi_cs_n_o = 1'b0;
      #400;
      for (int i = 15; i >= 0; i--)
      begin
         spi_sclk_o = 1'b0;
         spi_mosi_o = tx[i];
         #200;
         spi_sclk_o = 1'b1;
         rx = {rx[14:0], spi_miso_i};
         #200;
      end
      #200;
      spi_cs_n_o = 1'b1;
      // A released line shows no stale bit.
      spi_mosi_o = ~spi_mosi_o;
      #400;
   endtask : xfer
endmodule : icfr_host_model

// ---- verification/icfr_top_test.sv ----
/* Self-checking bench of the readout top with the host model.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
module icfr_top_test;
   logic        clk_sys_i = 1'b0;
   logic        srst_i    = 1'b1;
   logic [15:0] graw [3];
   logic [15:0] araw [3];
   logic        take, miso, oe, rdy, sclk, cs_n, mosi;
   logic        sync      = 1'b0;
   logic        prev      = 1'b0;
   logic [31:0] lfsr      = 32'h83e2;
   logic [15:0] expq [$];
   logic [15:0] got;
   int          err_count = 0;
   int          n_checks  = 0;
   int          cyc       = 0;
   int          gap       = 0;
   int          span      = 0;
   int          wid       = 0;
   event        got_ev;
   wire         miso_w    = oe ? miso : ~cyc[0];

   always #25 clk_sys_i = ~clk_sys_i;

   icfr_top #(.SAMPLE_CYC(200)) i_dut (.clk_sys_i, .srst_i,
      .gyro_raw_i(graw), .accl_raw_i(araw), .raw_take_o(take),
      .sync_i(sync), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
      .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(oe),
      .sample_ready_o(rdy));
   icfr_host_model i_host (.spi_sclk_o(sclk), .spi_cs_n_o(cs_n),
      .spi_mosi_o(mosi), .spi_miso_i(miso_w));

   // ------
   // Tasks
   // ------
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic conclude();
      $display("Checks %0d, errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : conclude
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [15:0] r;
      i_host.xfer({1'b1, a, d}, r);
   endtask : wr
   task automatic rd(input logic [6:0] a, input logic [15:0] e);
      logic [15:0] r;
      expq.push_back(e);
      i_host.xfer({1'b0, a, 8'h00}, r);
      i_host.xfer(16'h0000, got);
      ->got_ev;
   endtask : rd
   // Reads only start after a ready pulse has ended.
   task automatic settle();
      repeat (1000) @(negedge clk_sys_i);
      @(negedge clk_sys_i iff take);
      repeat (30) @(negedge clk_sys_i);
   endtask : settle
   task automatic rd_out(input int first, input logic [15:0] e [3]);
      for (int i = 0; i < 3; i++)
         rd(7'(4 + 2 * (first + i)), e[i]);
   endtask : rd_out

   always @(got_ev) check("reply", got, expq.pop_front());

   always @(negedge clk_sys_i)
   begin
      cyc++;
      sync <= cyc[6];
      if (take)
         gap++;
      // Measured while polarity is 1, so the pulse is the low part.
      if (rdy === 1'b0 && prev === 1'b1)
      begin
         span = gap;
         gap = 0;
         wid = 0;
      end
      if (rdy === 1'b0)
         wid++;
      prev = rdy;
      if (cyc == 40000)
      begin
         err_count++;
         conclude();
      end
   end

   initial
   begin
      for (int i = 0; i < 3; i++)
      begin
         lfsr = nxt(lfsr);
         graw[i] = lfsr[15:0];
         lfsr = nxt(lfsr);
         araw[i] = lfsr[15:0];
      end
      repeat (2) @(negedge clk_sys_i);
      srst_i = 1'b0;
      repeat (10) @(negedge clk_sys_i);
      rd(7'h60, icfr_pkg::MISC_RST);
      wr(7'h72, 8'h55);
      rd(7'h73, icfr_pkg::PRODUCT_IDENTIFIER_REGISTER);
      rd(7'h7e, 16'h0000);
      wr(7'h65, 8'h01);
      rd(7'h64, 16'h0100);
      wr(7'h65, 8'h00);
      wr(7'h60, 8'h01);
      settle();
      rd_out(0, graw);
      rd_out(3, araw);
      wr(7'h60, 8'h81);
      graw = '{16'h0100, 16'h0200, 16'h7fff};
      araw = '{16'h4000, 16'h4000, 16'h0000};
      settle();
      rd_out(0, '{16'h0110, 16'h0200, 16'h7fff});
      wr(7'h60, 8'h41);
      graw = '{16'h4000, 16'h0000, 16'h0000};
      araw = '{16'h0000, 16'h0000, 16'h0000};
      settle();
      rd_out(0, graw);
      rd_out(3, '{16'h0000, 16'h0008, 16'h0008});
      wr(7'h60, 8'h01);
      settle();
      rd_out(3, araw);
      wr(7'h64, 8'h03);
      repeat (2000) @(negedge clk_sys_i);
      @(negedge clk_sys_i iff rdy === 1'b1);
      check("span", 16'(span), 16'h0004);
      check("width", 16'(wid), 16'(icfr_pkg::RDY_WIDTH_CYC));
      wr(7'h60, 8'h00);
      @(negedge clk_sys_i iff take);
      check("idle", {15'h0000, rdy}, 16'h0000);
      wr(7'h68, 8'h80);
      rd(7'h60, icfr_pkg::MISC_RST);
      @(negedge clk_sys_i iff take);
      check("idle", {15'h0000, rdy}, 16'h0001);
      conclude();
   end
endmodule : icfr_top_test
